/* inc/rtcp_pkg.sv */
// Shared constants and types for the serially accessed timekeeping register set.
// Assumes one 25 MHz clock and memory strobes that are synchronous to it.
package rtcp_pkg;

    // Clock rate of the block.
    localparam int unsigned RTCP_CLK_HZ = 25_000_000;

    // Geometry of the serial register space.
    localparam int unsigned RTCP_NUM_REGS = 8;
    localparam int unsigned RTCP_REG_W = 8;
    localparam int unsigned RTCP_IDX_W = 3;
    localparam int unsigned RTCP_PTR_W = 6;
    localparam logic [5:0] RTCP_PTR_LAST = 6'h3F;
    localparam logic [2:0] RTCP_BIT_LAST = 3'h7;
    localparam logic [5:0] RTCP_PTR_FIRST = 6'h00;

    // Register indices in transfer order.
    localparam logic [2:0] RTCP_IDX_HOURS_AND_FORMAT = 3'h3;
    localparam logic [2:0] RTCP_IDX_WEEKDAY_AND_CONTROL = 3'h4;

    // Field positions.
    localparam int unsigned RTCP_HOUR_FMT_BIT = 7;
    localparam int unsigned RTCP_HOUR_PM_BIT = 5;
    localparam int unsigned RTCP_DAY_ABORT_IGN_BIT = 4;
    localparam int unsigned RTCP_DAY_OSC_STOP_BIT = 5;

    // Bits that exist in each register; the others always read zero.
    localparam logic [63:0] RTCP_LIVE_MASKS = 64'hFF1F_3F37_BF7F_7FFF;

    // Delivered state: control bits of the weekday register set, all else zero.
    localparam logic [63:0] RTCP_RESET_REGS = 64'h0000_0030_0000_0000;

    // Commit FIFO shape.
    localparam int unsigned RTCP_FIFO_DEPTH = 16;
    localparam int unsigned RTCP_FIFO_W = 11;

    // Sequencer states.
    typedef enum logic [1:0] {
        RTCP_ST_MATCH = 2'b00,
        RTCP_ST_MISS = 2'b01,
        RTCP_ST_XFER = 2'b10
    } rtcp_state_t;

endpackage

/* logic/rtcp_register_access.sv */
// Serial register access behind a memory socket, with its byte commit FIFO.
// Assumes chip enable, output enable, write enable, abort and power-fail are
// synchronous to i_clk and that each memory cycle spans at least one clock.
// Assumes also that the host keeps to the unlock protocol: one read, then the
// pattern writes, then whole bytes; anything else is dropped, never stored.
// Time counting itself lives in the timekeeping core fed by the register views.
// Between memory cycles the strobes must return high for at least one clock.
`timescale 1ns/100ps

module rtcp_fifo #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_nrst,
    // Discard everything held.
    input wire logic i_flush,
    // Filling side.
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Draining side.
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    // Address width of the storage; DEPTH is a power of two so pointers wrap.
    localparam int unsigned AW = $clog2(DEPTH);

    // Whole buffer state, storage included, registered as one word.
    // The count has one spare bit so that full and empty differ.
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
    } rtcp_fifo_st_t;

    rtcp_fifo_st_t st_q;
    rtcp_fifo_st_t st_d;
    // Handshakes that actually move a word this cycle.
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign o_in_ready = (st_q.cnt != (AW + 1)'(DEPTH));
    assign o_out_valid = (st_q.cnt != '0);
    assign o_out_data = st_q.mem[st_q.rd];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Pointer and count update; a flush empties the buffer.
    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wr] = i_in_data;
            st_d.wr = st_q.wr + 1'b1;
        end
        if (pop) begin
            st_d.rd = st_q.rd + 1'b1;
        end
        // A push and a pop in one cycle leave the count unchanged.
        st_d.cnt = st_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        // Flush wins over a push in the same cycle, so a dropped byte never lands.
        // Stale words stay in storage but can no longer be read.
        if (i_flush) begin
            st_d.rd = '0;
            st_d.wr = '0;
            st_d.cnt = '0;
        end
    end

    // State register.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule // rtcp_fifo

module rtcp_register_access import rtcp_pkg::*; #(
    // Unlock comparison pattern, bit 0 sent first.
    parameter logic [63:0] UNLOCK_PATTERN = 64'h0123_4567_89AB_CDEF
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_nrst,
    // Memory cycle strobes from the host, active low.
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    // Serial data pin split into its three signals.
    input wire logic i_serial_bit_line,
    output logic o_serial_bit_line,
    output logic o_serial_bit_line_oe,
    // Abort pin, active low.
    input wire logic i_abort_n,
    // Supply below power_fail_threshold, active high.
    input wire logic i_power_fail_threshold,
    // Conditioned chip enable to the memory, active low.
    output logic o_mem_ce_n,
    // Register state seen by the timekeeping core.
    output logic [63:0] o_time_regs,
    output logic o_hour_12_mode,
    output logic o_hour_pm,
    output logic o_osc_run,
    output logic o_clock_access
);
    // All state of the block outside the commit FIFO in one word: sequencer, cycle capture, serial
    // shifter, pending byte and the live registers. Everything a cycle does
    // is decided at the clock edge where that cycle ends, so a host that holds
    // a strobe for many clocks still counts as one bit.
    typedef struct packed {
        rtcp_state_t state;
        logic [RTCP_PTR_W-1:0] ptr;
        // Capture of the memory cycle in progress.
        logic cyc_act;
        logic cyc_wr;
        logic cyc_data;
        // Serial shifter and the byte it hands to the buffer.
        logic [RTCP_REG_W-1:0] shadow;
        logic wr_seen;
        logic push;
        logic [RTCP_FIFO_W-1:0] push_data;
        logic out_bit;
        // Live timekeeping registers, register 0 in the low byte.
        logic [RTCP_NUM_REGS-1:0][RTCP_REG_W-1:0] regs;
    } rtcp_st_t;

    rtcp_st_t st_q;
    rtcp_st_t st_d;
    logic act;
    logic cyc_done;
    logic abort;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [RTCP_FIFO_W-1:0] fifo_out_data;
    logic drain_ready;
    logic flush;
    logic in_xfer;
    logic cyc_blocked;
    logic [RTCP_IDX_W-1:0] cur_idx;
    logic [RTCP_REG_W-1:0] cur_byte;
    logic [RTCP_IDX_W-1:0] commit_idx;
    logic [RTCP_REG_W-1:0] commit_byte;

    // Returns the readable bits of one register, unused positions zeroed.
    // Used on commit as well as on read, so an unused bit never becomes live.
    function automatic logic [RTCP_REG_W-1:0] live_bits(
        input logic [RTCP_IDX_W-1:0] idx,
        input logic [RTCP_REG_W-1:0] v
    );
        live_bits = v & RTCP_LIVE_MASKS[idx*RTCP_REG_W +: RTCP_REG_W];
    endfunction

    // Register number addressed by a transfer pointer.
    function automatic logic [RTCP_IDX_W-1:0] reg_of(input logic [RTCP_PTR_W-1:0] p);
        reg_of = p[RTCP_PTR_W-1 -: RTCP_IDX_W];
    endfunction

    // Bit number within that register; the low bits step first.
    function automatic logic [RTCP_IDX_W-1:0] bit_of(input logic [RTCP_PTR_W-1:0] p);
        bit_of = p[RTCP_IDX_W-1:0];
    endfunction

    // A memory cycle is active while chip enable and a direction strobe are low and power is good.
    assign act = !i_ce_n && (!i_oe_n || !i_we_n) && !i_power_fail_threshold;
    assign cyc_done = st_q.cyc_act && !act;
    assign abort = !st_q.regs[RTCP_IDX_WEEKDAY_AND_CONTROL][RTCP_DAY_ABORT_IGN_BIT]
        && !i_abort_n;
    assign flush = abort && (st_q.state == RTCP_ST_XFER);
    // Bytes are committed only between transfers and while power is good.
    // A commit during power fail could tear a register, so it waits.
    assign drain_ready = (st_q.state != RTCP_ST_XFER) && !i_power_fail_threshold;

    // Transfer phase, and a cycle end that is lost while a pending byte meets a full buffer.
    assign in_xfer = (st_q.state == RTCP_ST_XFER);
    assign cyc_blocked = st_q.push && !fifo_in_ready;

    // Byte under the pointer as the host may read it.
    assign cur_idx = reg_of(st_q.ptr);
    assign cur_byte = live_bits(cur_idx, st_q.regs[cur_idx]);

    // Buffered byte split into its register number and its value.
    // The value is kept as written apart from its unused bits; the host supplies the decimal digits.
    assign commit_idx = fifo_out_data[RTCP_REG_W +: RTCP_IDX_W];
    assign commit_byte = live_bits(commit_idx, fifo_out_data[RTCP_REG_W-1:0]);

    // Byte commit buffer between the serial shifter and the live registers.
    rtcp_fifo #(
        .WIDTH(RTCP_FIFO_W),
        .DEPTH(RTCP_FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_flush(flush),
        .i_in_valid(st_q.push),
        .i_in_data(st_q.push_data),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fifo_out_valid),
        .o_out_data(fifo_out_data),
        .i_out_ready(drain_ready)
    );

    // Sequencer: recognition, clock transfer and byte commit.
    always_comb begin
        st_d = st_q;
        // Latch the cycle kind and the last data seen while it is active.
        if (act) begin
            st_d.cyc_act = 1'b1;
            st_d.cyc_wr = !i_we_n;
            st_d.cyc_data = i_serial_bit_line;
        end else begin
            st_d.cyc_act = 1'b0;
        end
        // A pending byte leaves once the buffer takes it.
        if (st_q.push && fifo_in_ready) begin
            st_d.push = 1'b0;
        end
        // Present the addressed bit for the next read.
        st_d.out_bit = cur_byte[bit_of(st_q.ptr)];
        // Commit a buffered byte; commits run only outside transfers, so a
        // cut transfer leaves nothing behind in the live registers.
        if (fifo_out_valid && drain_ready) begin
            st_d.regs[commit_idx] = commit_byte;
        end
        // Abort outranks a cycle end in the same clock, so that cycle is lost too.
        // In a transfer the buffer is flushed alongside, through the flush signal above.
        if (abort) begin
            // Recognition or transfer is dropped without touching registers.
            st_d.state = RTCP_ST_MATCH;
            st_d.ptr = RTCP_PTR_FIRST;
            st_d.wr_seen = 1'b0;
            st_d.push = 1'b0;
        // Each cycle is processed once, at the edge where it ends.
        end else if (cyc_done && !cyc_blocked) begin
            unique case (st_q.state)
                RTCP_ST_MATCH: begin
                    // A read restarts recognition; a wrong bit parks us in MISS.
                    if (!st_q.cyc_wr) begin
                        st_d.ptr = RTCP_PTR_FIRST;
                    end else if (st_q.cyc_data == UNLOCK_PATTERN[st_q.ptr]) begin
                        st_d.ptr = st_q.ptr + 1'b1;
                        if (st_q.ptr == RTCP_PTR_LAST) begin
                            st_d.state = RTCP_ST_XFER;
                            st_d.ptr = RTCP_PTR_FIRST;
                        end
                    end else begin
                        st_d.state = RTCP_ST_MISS;
                    end
                end
                RTCP_ST_MISS: begin
                    // Writes are ignored until a read re-arms recognition.
                    if (!st_q.cyc_wr) begin
                        st_d.state = RTCP_ST_MATCH;
                        st_d.ptr = RTCP_PTR_FIRST;
                    end
                end
                RTCP_ST_XFER: begin
                    // Write bits shift in; read bits keep the register's own value.
                    st_d.shadow = {(st_q.cyc_wr ? st_q.cyc_data : st_q.out_bit),
                        st_q.shadow[RTCP_REG_W-1:1]};
                    st_d.wr_seen = st_q.wr_seen || st_q.cyc_wr;
                    // A byte that saw no write is not queued, so reads change nothing.
                    if (bit_of(st_q.ptr) == RTCP_BIT_LAST) begin
                        st_d.wr_seen = 1'b0;
                        if (st_q.wr_seen || st_q.cyc_wr) begin
                            st_d.push = 1'b1;
                            st_d.push_data = {reg_of(st_q.ptr), st_d.shadow};
                        end
                    end
                    st_d.ptr = st_q.ptr + 1'b1;
                    // The last bit of the last register hands back to the memory.
                    // Queued bytes then commit one per clock.
                    if (st_q.ptr == RTCP_PTR_LAST) begin
                        st_d.state = RTCP_ST_MATCH;
                        st_d.ptr = RTCP_PTR_FIRST;
                    end
                end
                // Unused code: recover to recognition from the first bit.
                default: begin
                    st_d.state = RTCP_ST_MATCH;
                    st_d.ptr = RTCP_PTR_FIRST;
                end
            endcase
        end
    end

    // State register; registers start in their delivered state.
    // A reset in mid-run also drops any transfer and any queued byte.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= '0;
            st_q.regs <= RTCP_RESET_REGS;
        end else begin
            st_q <= st_d;
        end
    end

    // Memory chip enable: forced off on power fail, blocked for clock cycles.
    assign o_mem_ce_n = i_power_fail_threshold ? 1'b1
        : (in_xfer ? 1'b1 : i_ce_n);
    // Power fail acts on this output directly, whatever the host is doing.

    // The pin is driven only during a read cycle of a clock transfer.
    // Writes and memory cycles leave it to the host and the memory.
    assign o_serial_bit_line_oe = (st_q.state == RTCP_ST_XFER) && act && i_we_n;
    assign o_serial_bit_line = st_q.out_bit;

    // Register views for the timekeeping core.
    // In 24-hour format bit 5 of the hours register stays a tens digit,
    // so the afternoon flag is forced low there.
    assign o_time_regs = st_q.regs;
    assign o_hour_12_mode = st_q.regs[RTCP_IDX_HOURS_AND_FORMAT][RTCP_HOUR_FMT_BIT];
    assign o_hour_pm = o_hour_12_mode
        && st_q.regs[RTCP_IDX_HOURS_AND_FORMAT][RTCP_HOUR_PM_BIT];
    assign o_osc_run = !st_q.regs[RTCP_IDX_WEEKDAY_AND_CONTROL][RTCP_DAY_OSC_STOP_BIT];
    assign o_clock_access = (st_q.state == RTCP_ST_XFER);
endmodule // rtcp_register_access

/* testbench/rtcp_checker.sv */
// Port checker for the serial register access block.
// Bound to rtcp_register_access; sees only its ports.
`timescale 1ns/100ps
module rtcp_checker import rtcp_pkg::*; (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_nrst,
    // Inputs watched.
    input wire logic i_ce_n,
    input wire logic i_we_n,
    input wire logic i_abort_n,
    input wire logic i_power_fail_threshold,
    // Outputs watched.
    input wire logic o_serial_bit_line_oe,
    input wire logic o_mem_ce_n,
    input wire logic [63:0] o_time_regs,
    input wire logic o_hour_12_mode,
    input wire logic o_hour_pm,
    input wire logic o_osc_run,
    input wire logic o_clock_access
);
    // All properties share one clock and reset.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // Relations between the ports.
    property p_pf; i_power_fail_threshold |-> o_mem_ce_n; endproperty
    property p_pass; !i_power_fail_threshold && !o_clock_access |-> o_mem_ce_n == i_ce_n;
    endproperty
    property p_xce; o_clock_access |-> o_mem_ce_n; endproperty
    property p_oe; o_serial_bit_line_oe |-> o_clock_access && !i_ce_n && i_we_n; endproperty
    property p_fmt; o_hour_12_mode == o_time_regs[31]; endproperty
    property p_pm; o_hour_pm == (o_time_regs[31] && o_time_regs[29]); endproperty
    property p_osc; o_osc_run == !o_time_regs[37]; endproperty
    property p_zero; (o_time_regs & ~RTCP_LIVE_MASKS) == 64'h0000_0000_0000_0000; endproperty
    property p_hold; o_clock_access |-> $stable(o_time_regs); endproperty
    property p_abort; o_clock_access && !i_abort_n && !o_time_regs[36] |-> ##[1:2] !o_clock_access;
    endproperty
    a_pf: assert property (p_pf) else $error("memory enabled in power fail");
    a_pass: assert property (p_pass) else $error("chip enable not passed");
    a_xce: assert property (p_xce) else $error("memory enabled in transfer");
    a_oe: assert property (p_oe) else $error("pin driven outside a read");
    a_fmt: assert property (p_fmt) else $error("hour format wrong");
    a_pm: assert property (p_pm) else $error("afternoon flag wrong");
    a_osc: assert property (p_osc) else $error("oscillator control wrong");
    a_zero: assert property (p_zero) else $error("unused bit set");
    a_hold: assert property (p_hold) else $error("register changed in transfer");
    a_abort: assert property (p_abort) else $error("abort not taken");
    // Main scenarios reached.
    c_unlock: cover property ($rose(o_clock_access));
    c_abort: cover property (o_clock_access && !i_abort_n && !o_time_regs[36]);
    c_pf: cover property (i_power_fail_threshold && !i_ce_n);
endmodule // rtcp_checker

bind rtcp_register_access rtcp_checker rtcp_checker_i (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_ce_n(i_ce_n), .i_we_n(i_we_n),
    .i_abort_n(i_abort_n), .i_power_fail_threshold(i_power_fail_threshold),
    .o_serial_bit_line_oe(o_serial_bit_line_oe), .o_mem_ce_n(o_mem_ce_n),
    .o_time_regs(o_time_regs), .o_hour_12_mode(o_hour_12_mode), .o_hour_pm(o_hour_pm),
    .o_osc_run(o_osc_run), .o_clock_access(o_clock_access));

/* testbench/rtcp_host_model.sv */
// Host model running memory cycles on the socket strobes.
// Assumes one clock; it changes its outputs on the falling edge.
`timescale 1ns/100ps
module rtcp_host_model (
    // Clock and the pin level on the wire.
    input wire logic i_clk,
    input wire logic i_pin,
    // Strobes and data toward the device.
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic o_data
);
    // Idle strobes from time zero.
    initial begin
        o_ce_n = 1'h1;
        o_oe_n = 1'h1;
        o_we_n = 1'h1;
        o_data = 1'h0;
    end
    // One cycle; a released line shows the inverse of its last value.
    task automatic cyc(input logic wr, input logic b, output logic rd);
        @(negedge i_clk);
        o_ce_n = 1'h0;
        o_we_n = !wr;
        o_oe_n = wr;
        o_data = wr ? b : !o_data;
        repeat (3) @(posedge i_clk);
        rd = i_pin;
        @(negedge i_clk);
        o_ce_n = 1'h1;
        o_we_n = 1'h1;
        o_oe_n = 1'h1;
        o_data = !o_data;
        repeat (2) @(posedge i_clk);
    endtask
    // A read resets the pointer, then the pattern goes out low bit first.
    task automatic unlock(input logic [63:0] pat);
        logic d;
        cyc(1'h0, 1'h0, d);
        for (int i = 0; i < 64; i++) cyc(1'h1, pat[i], d);
    endtask
endmodule // rtcp_host_model

/* testbench/tb_top.sv */
// Self-checking bench for the serial register access block.
// Assumes the host model file and the bound checker.
`timescale 1ns/100ps
module tb_top import rtcp_pkg::*; ();
    localparam logic [63:0] PAT = 64'hC53A_A35C_C53A_A35C;
    typedef struct packed {logic [7:0] wr; logic [7:0] ex;} rtcp_row_t;
    // Written byte beside the byte it should leave, register 0 first.
    rtcp_row_t rows [8] = '{'{8'h99, 8'h99}, '{8'hFF, 8'h7F}, '{8'hFF, 8'h7F},
        '{8'hF2, 8'hB2}, '{8'hC5, 8'h05}, '{8'hFF, 8'h3F}, '{8'hFF, 8'h1F}, '{8'h24, 8'h24}};
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic abort_n = 1'h1;
    logic pf = 1'h0;
    logic ce_n, oe_n, we_n, h_data, d_out, d_oe, mem_ce_n, hr12, pm, osc, acc, d;
    logic [63:0] regs, exp, got;
    int n_fail = 0;
    int cmp_count = 0;
    // The pin follows whoever drives it.
    wire logic pin = d_oe ? d_out : h_data;
    always #20 clk = !clk;
    rtcp_register_access #(.UNLOCK_PATTERN(PAT)) rtcp_register_access_i (
        .i_clk(clk), .i_nrst(nrst), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
        .i_serial_bit_line(pin), .o_serial_bit_line(d_out), .o_serial_bit_line_oe(d_oe),
        .i_abort_n(abort_n), .i_power_fail_threshold(pf), .o_mem_ce_n(mem_ce_n),
        .o_time_regs(regs), .o_hour_12_mode(hr12), .o_hour_pm(pm), .o_osc_run(osc),
        .o_clock_access(acc));
    rtcp_host_model rtcp_host_model_i (.i_clk(clk), .i_pin(pin), .o_ce_n(ce_n),
        .o_oe_n(oe_n), .o_we_n(we_n), .o_data(h_data));
    // Compare and count.
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] ex);
        cmp_count++;
        if (seen !== ex) begin
            n_fail++;
            $display("MISMATCH %s exp %h seen %h", nm, ex, seen);
        end
    endtask
    // Print counts and verdict, then stop.
    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Low pulse on the abort pin between cycles.
    task automatic pulse();
        @(negedge clk);
        abort_n = 1'h0;
        repeat (2) @(negedge clk);
        abort_n = 1'h1;
    endtask
    // A hang counts as a mismatch.
    initial begin
        #1_000_000;
        n_fail++;
        close_out();
    end
    // Tests.
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        nrst = 1'h1;
        chk("reset_regs", regs, RTCP_RESET_REGS);
        chk("osc_run", osc, 1'h0);
        chk("mem_ce", mem_ce_n, ce_n);
        $display("reset test done");
        rtcp_host_model_i.unlock(PAT);
        chk("unlocked", acc, 1'h1);
        chk("mem_off", mem_ce_n, 1'h1);
        exp = '0;
        for (int i = 0; i < 8; i++) begin
            exp[i*8 +: 8] = rows[i].ex;
            if (i == 4) pulse();
            for (int j = 0; j < 8; j++) rtcp_host_model_i.cyc(1'h1, rows[i].wr[j], d);
        end
        repeat (12) @(negedge clk);
        chk("regs", regs, exp);
        chk("released", acc, 1'h0);
        chk("fmt", hr12, 1'h1);
        chk("pm", pm, 1'h1);
        chk("osc", osc, 1'h1);
        $display("write test done");
        // A part pattern, then a read restarts recognition.
        for (int k = 0; k < 10; k++) rtcp_host_model_i.cyc(1'h1, PAT[k], d);
        rtcp_host_model_i.unlock(PAT);
        chk("restart", acc, 1'h1);
        for (int k = 0; k < 64; k++) rtcp_host_model_i.cyc(1'h0, 1'h0, got[k]);
        chk("readback", got, exp);
        $display("read test done");
        // Abort in mid-transfer must leave the registers alone.
        rtcp_host_model_i.unlock(PAT);
        for (int k = 0; k < 10; k++) rtcp_host_model_i.cyc(1'h1, 1'h0, d);
        pulse();
        repeat (12) @(negedge clk);
        chk("abort_acc", acc, 1'h0);
        chk("abort_regs", regs, exp);
        // Power fail during a cycle keeps the memory off.
        pf = 1'h1;
        fork
            rtcp_host_model_i.cyc(1'h1, 1'h0, d);
            begin
                repeat (2) @(negedge clk);
                chk("pf_ce", mem_ce_n, 1'h1);
            end
        join
        @(negedge clk);
        pf = 1'h0;
        // With power good an ordinary cycle passes chip enable through.
        fork
            rtcp_host_model_i.cyc(1'h0, 1'h0, d);
            begin
                repeat (2) @(negedge clk);
                chk("pass_ce", mem_ce_n, 1'h0);
            end
        join
        $display("fault tests done");
        close_out();
    end
endmodule // tb_top
